// ---- hw/supervisor_pkg.sv ----
// Purpose: shared constants and types of the supply supervisor mode control
// Assumes: 25 MHz pclk, 32-bit APB with byte offsets below
// Notes: settle and wake counts fit 12 bits
package supervisor_pkg;
   localparam int CLK_MHZ = 25;
   localparam int SLOW_WAKE_US = 150;
   localparam int FAST_WAKE_US = 2;
   localparam logic [11:0] SLOW_CYC = 12'(SLOW_WAKE_US * CLK_MHZ);
   localparam logic [11:0] FAST_CYC = 12'(FAST_WAKE_US * CLK_MHZ);

   localparam logic [7:0] OFS_LCTL = 8'h00;
   localparam logic [7:0] OFS_HCTL = 8'h04;
   localparam logic [7:0] OFS_FLAGS = 8'h08;
   localparam logic [7:0] OFS_ISTAT = 8'h0C;
   localparam logic [7:0] OFS_IMASK = 8'h10;
   localparam logic [7:0] OFS_STATE = 8'h14;

   localparam logic [6:0] LCTL_RST = 7'h0B;
   localparam logic [6:0] HCTL_RST = 7'h0B;
   localparam logic [5:0] IMASK_RST = 6'h00;

   localparam int IRQ_LSUP = 0;
   localparam int IRQ_LMON = 1;
   localparam int IRQ_HSUP = 2;
   localparam int IRQ_HMON = 3;
   localparam int IRQ_WAKE = 4;
   localparam int IRQ_SETTLED = 5;

   typedef enum logic [1:0] {SV_OFF, SV_NORMAL, SV_FULL} sv_state_t;
   typedef enum logic [1:0] {PM_ACTIVE, PM_LIGHT, PM_DEEP, PM_WAKE} pmode_t;

   // extra: event-to-reset routing (low) or overvoltage protect (high)
   typedef struct packed {
      logic extra;
      logic auto_ctl;
      logic mon_fp;
      logic mon_en;
      logic sup_fp;
      logic sup_mode;
      logic sup_en;
   } side_ctrl_t;

   typedef struct packed {
      sv_state_t hmon;
      sv_state_t hsup;
      sv_state_t lmon;
      sv_state_t lsup;
   } sv_states_t;

   typedef struct packed {
      logic hmon;
      logic hsup;
      logic lmon;
      logic lsup;
   } trips_t;

   function automatic sv_state_t decode_sv(input logic en, input logic keep,
         input logic fp, input logic auto_ctl, input logic deep);
      sv_state_t base;
      base = fp ? SV_FULL : SV_NORMAL;
      if (!en) begin
         return SV_OFF;
      end
      if (!deep) begin
         return base;
      end
      if (!keep) begin
         return SV_OFF;
      end
      if (!auto_ctl) begin
         return base;
      end
      return fp ? SV_NORMAL : SV_OFF;
   endfunction
endpackage

// ---- hw/state_decoder.sv ----
// Purpose: decode control bits into supervisor and monitor states
// Assumes: deep selects the deep-sleep column
// Notes: purely combinational
`timescale 1ns/10ps
module state_decoder
   import supervisor_pkg::*;
(
   input wire side_ctrl_t lctl,
   input wire side_ctrl_t hctl,
   input wire logic deep,
   output sv_states_t states,
   output logic slow
);
   always_comb begin
      states.lsup = decode_sv(lctl.sup_en, lctl.sup_mode, lctl.sup_fp,
                              lctl.auto_ctl, deep); // [R1] [R2] [R3]
      states.lmon = decode_sv(lctl.mon_en, 1'b1, lctl.mon_fp,
                              lctl.auto_ctl, deep); // [R4]
      states.hsup = decode_sv(hctl.sup_en, hctl.sup_mode, hctl.sup_fp,
                              hctl.auto_ctl, deep); // [R7]
      states.hmon = decode_sv(hctl.mon_en, 1'b1, hctl.mon_fp,
                              hctl.auto_ctl, deep); // [R8]
      // automatic high side keeps the monitor quiet in deep sleep
      if (deep && hctl.auto_ctl) begin
         states.hmon = SV_OFF; // [R9]
      end
      // normal-performance low side forces the slow wake path
      slow = (lctl.sup_en && !lctl.sup_fp) || (lctl.mon_en && !lctl.mon_fp); // [R5]
   end
endmodule

// ---- hw/delay_timer.sv ----
// Purpose: down-counter for settling and wake delays
// Assumes: load wins over clear
// Notes: busy holds from the load edge for count cycles
`timescale 1ns/10ps
module delay_timer
   import supervisor_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic clear,
   input wire logic [11:0] count,
   output logic busy,
   output logic done
);
   logic [11:0] cnt_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 12'h000;
      end else if (load) begin
         cnt_q <= count;
      end else if (clear) begin
         cnt_q <= 12'h000;
      end else if (cnt_q != 12'h000) begin
         cnt_q <= cnt_q - 12'h001;
      end
   end

   assign busy = (cnt_q != 12'h000);
   assign done = (cnt_q == 12'h001) && !load && !clear;
endmodule

// ---- hw/supply_supervisor_ctrl.sv ----
// Operation
// R1: low supervisor disabled means off in every mode and fast wake path
// R2: enabled low supervisor: full-perf bit picks normal or full; mode 0 off in deep
// R3: deep-mode bit 1: manual keeps state, automatic drops one level
// R4: low monitor off when disabled, else full-perf bit; same deep-sleep drop
// R5: any low side part in normal performance gives slow wake, else fast
// R6: slow wake holds execution about 150 us after leaving deep sleep
// R7: high supervisor decodes like the low supervisor with its own auto bit
// R8: high monitor decodes like the low monitor with the high auto bit
// R9: automatic high side keeps the high monitor off throughout deep sleep
// R10: control writes set both settling flags; deep sleep waits till clear
// R11: interrupt right after deep-sleep entry still wakes the device
// R12: external reset, power cycle or power-up clear end any sleep state
// R13: overvoltage enable makes a high monitor trip raise power-on reset
// R14: low side events go to power-on reset or interrupt per routing bit
// R15: software adds a 150 us delay when it needs fast servicing
// R16: software picks slow wake or manual high side to avoid lost wakes
// R17: deep-sleep states are latched at request acceptance and applied together
//
// Purpose: supply supervisor and monitor mode control with APB registers
// Assumes: all inputs synchronous to pclk; lpm_req held until lpm_ack
// Notes: one wait-free APB access phase; prdata sampled at setup
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
module supply_supervisor_ctrl
   import supervisor_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic lpm_req,
   input wire logic lpm_deep,
   output logic lpm_ack,
   input wire logic wake_irq,
   input wire logic ext_reset_req,
   input wire logic power_up_clear,
   input wire trips_t trip,
   output sv_states_t sv_state,
   output pmode_t pmode,
   output logic wake_slow,
   output logic cpu_hold,
   output logic por_req,
   output logic irq
);
   side_ctrl_t lctl_q;
   side_ctrl_t hctl_q;
   logic [5:0] istat_q;
   logic [5:0] imask_q;
   logic [5:0] ev;
   logic [31:0] rdata;
   logic wr;
   logic wr_ctl;
   logic wr_l;
   logic wr_h;
   logic mapped;
   logic accept;
   logic restart;
   logic l_busy;
   logic h_busy;
   logic l_done;
   logic h_done;
   logic w_busy;
   logic w_done;
   logic w_load;
   logic slow_now;
   logic slow_deep;
   logic low_fp_n;
   logic high_fp_n;
   logic lo_event;
   logic ovp_trip;
   sv_states_t run_states;
   sv_states_t deep_states;
   side_ctrl_t wl;

   assign wl = side_ctrl_t'(pwdata[6:0]);
   assign wr = psel && penable && pwrite;
   assign wr_l = wr && (paddr == OFS_LCTL);
   assign wr_h = wr && (paddr == OFS_HCTL);
   assign wr_ctl = wr_l || wr_h;
   assign restart = ext_reset_req || power_up_clear;

   always_comb begin
      case (paddr)
         OFS_LCTL, OFS_HCTL, OFS_FLAGS, OFS_ISTAT, OFS_IMASK, OFS_STATE: begin
            mapped = 1'b1;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   always_comb begin
      rdata = 32'h0000_0000;
      case (paddr)
         OFS_LCTL: begin
            rdata[6:0] = lctl_q;
         end
         OFS_HCTL: begin
            rdata[6:0] = hctl_q;
         end
         OFS_FLAGS: begin
            rdata[1:0] = {h_busy, l_busy}; // [R10]
         end
         OFS_ISTAT: begin
            rdata[5:0] = istat_q;
         end
         OFS_IMASK: begin
            rdata[5:0] = imask_q;
         end
         OFS_STATE: begin
            rdata[10:0] = {wake_slow, pmode, sv_state};
         end
         default: begin
            rdata = 32'h0000_0000;
         end
      endcase
   end

   // answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (psel && !penable) begin
            prdata <= rdata;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lctl_q <= side_ctrl_t'(LCTL_RST);
         hctl_q <= side_ctrl_t'(HCTL_RST);
         imask_q <= IMASK_RST;
      end else begin
         if (wr_l) begin
            lctl_q <= wl;
         end
         if (wr_h) begin
            hctl_q <= wl;
         end
         if (wr && paddr == OFS_IMASK) begin
            imask_q <= pwdata[5:0];
         end
      end
   end

   // settle length follows the new full-performance choice of each side
   assign low_fp_n = wr_l ? wl.sup_fp : lctl_q.sup_fp;
   assign high_fp_n = wr_h ? wl.sup_fp : hctl_q.sup_fp;

   delay_timer u_low_settle (
      .pclk(pclk),
      .presetn(presetn),
      .load(wr_ctl), // [R10]
      .clear(1'b0),
      .count(low_fp_n ? FAST_CYC : SLOW_CYC),
      .busy(l_busy),
      .done(l_done)
   );

   delay_timer u_high_settle (
      .pclk(pclk),
      .presetn(presetn),
      .load(wr_ctl), // [R10]
      .clear(1'b0),
      .count(high_fp_n ? FAST_CYC : SLOW_CYC),
      .busy(h_busy),
      .done(h_done)
   );

   state_decoder u_run_dec (
      .lctl(lctl_q),
      .hctl(hctl_q),
      .deep(1'b0),
      .states(run_states),
      .slow(slow_now)
   );

   state_decoder u_deep_dec (
      .lctl(lctl_q),
      .hctl(hctl_q),
      .deep(1'b1),
      .states(deep_states),
      .slow(slow_deep)
   );

   // deep entry waits for both settling flags, light entry does not
   assign accept = lpm_req && !lpm_ack && (pmode == PM_ACTIVE) && !restart &&
                   (!lpm_deep || (!l_busy && !h_busy && !wr_ctl)); // [R10]
   assign w_load = (pmode == PM_DEEP && wake_irq) ||
                   (accept && lpm_deep && wake_irq); // [R11]

   delay_timer u_wake (
      .pclk(pclk),
      .presetn(presetn),
      .load(w_load && !restart),
      .clear(restart), // [R12]
      .count(slow_deep ? SLOW_CYC : FAST_CYC), // [R6]
      .busy(w_busy),
      .done(w_done)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pmode <= PM_ACTIVE;
         lpm_ack <= 1'b0;
      end else begin
         lpm_ack <= accept;
         if (restart) begin
            pmode <= PM_ACTIVE; // [R12]
         end else begin
            case (pmode)
               PM_ACTIVE: begin
                  if (accept && !lpm_deep) begin
                     pmode <= wake_irq ? PM_ACTIVE : PM_LIGHT;
                  end else if (accept) begin
                     pmode <= wake_irq ? PM_WAKE : PM_DEEP; // [R11]
                  end
               end
               PM_LIGHT: begin
                  if (wake_irq) begin
                     pmode <= PM_ACTIVE;
                  end
               end
               PM_DEEP: begin
                  if (wake_irq) begin
                     pmode <= PM_WAKE; // [R11]
                  end
               end
               PM_WAKE: begin
                  if (w_done) begin
                     pmode <= PM_ACTIVE; // [R6]
                  end
               end
               default: begin
                  pmode <= PM_ACTIVE;
               end
            endcase
         end
      end
   end

   // deep states and wake path are captured once at acceptance
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sv_state <= sv_states_t'(8'h00);
         wake_slow <= 1'b0;
      end else if (restart) begin
         sv_state <= run_states;
      end else if (accept && lpm_deep) begin
         sv_state <= deep_states; // [R17]
         wake_slow <= slow_deep; // [R5]
      end else if (pmode == PM_ACTIVE || pmode == PM_LIGHT || w_done) begin
         sv_state <= run_states; // [R1] [R2] [R4] [R7] [R8]
         wake_slow <= slow_now;
      end
   end

   // execution is masked from one cycle after the wake load to the end of the delay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_hold <= 1'b0;
      end else begin
         cpu_hold <= w_busy && !w_done && !restart; // [R6]
      end
   end

   assign lo_event = (trip.lsup && sv_state.lsup != SV_OFF) ||
                     (trip.lmon && sv_state.lmon != SV_OFF);
   assign ovp_trip = hctl_q.extra && trip.hmon && sv_state.hmon != SV_OFF;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_req <= 1'b0;
      end else begin
         por_req <= ovp_trip || (lctl_q.extra && lo_event); // [R13] [R14]
      end
   end

   always_comb begin
      ev = 6'h00;
      ev[IRQ_LSUP] = !lctl_q.extra && trip.lsup && sv_state.lsup != SV_OFF; // [R14]
      ev[IRQ_LMON] = !lctl_q.extra && trip.lmon && sv_state.lmon != SV_OFF; // [R14]
      ev[IRQ_HSUP] = trip.hsup && sv_state.hsup != SV_OFF;
      ev[IRQ_HMON] = !hctl_q.extra && trip.hmon && sv_state.hmon != SV_OFF;
      ev[IRQ_WAKE] = w_done;
      ev[IRQ_SETTLED] = l_done || h_done;
   end

   // a new event wins over a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_q <= 6'h00;
      end else if (wr && paddr == OFS_ISTAT) begin
         istat_q <= (istat_q & ~pwdata[5:0]) | ev;
      end else begin
         istat_q <= istat_q | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat_q & imask_q);
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence ctl_write_s;
      wr_ctl;
   endsequence

   sequence flags_up_s;
      l_busy && h_busy;
   endsequence

   settle_flags_a: assert property ( // [R10]
      ctl_write_s |=> flags_up_s)
      else $error("settling flags not set after control write");

   deep_gate_a: assert property ( // [R10]
      (lpm_ack && (pmode == PM_DEEP || pmode == PM_WAKE))
         |-> (!$past(l_busy) && !$past(h_busy)))
      else $error("deep sleep accepted while settling");

   slow_wake_a: assert property ( // [R6]
      (pmode == PM_DEEP && wake_irq && wake_slow && !restart)
         |=> ##1 cpu_hold [*8])
      else $error("slow wake hold too short");

   fast_wake_a: assert property ( // [R5]
      (pmode == PM_DEEP && wake_irq && !wake_slow && !restart)
         |-> ##[1:60] pmode == PM_ACTIVE)
      else $error("fast wake did not return to active");

   deep_latch_a: assert property ( // [R17]
      (accept && lpm_deep && !wake_irq) |=> sv_state == $past(deep_states))
      else $error("deep states not latched at acceptance");

   deep_hmon_a: assert property ( // [R9]
      (pmode == PM_DEEP && hctl_q.auto_ctl && $stable(hctl_q))
         |-> sv_state.hmon == SV_OFF)
      else $error("high monitor active in automatic deep sleep");

   lsup_off_a: assert property ( // [R1]
      (pmode == PM_ACTIVE && !lctl_q.sup_en && $stable(lctl_q))
         |=> sv_state.lsup == SV_OFF)
      else $error("disabled low supervisor not off");

   ovp_por_a: assert property ( // [R13]
      ovp_trip |=> por_req)
      else $error("overvoltage did not raise reset");

   restart_a: assert property ( // [R12]
      restart |=> pmode == PM_ACTIVE && !cpu_hold)
      else $error("restart left device asleep");

   early_irq_a: assert property ( // [R11]
      (accept && lpm_deep && wake_irq) |=> pmode == PM_WAKE)
      else $error("interrupt at deep entry lost");

   irq_level_a: assert property (
      (|(istat_q & imask_q)) |=> irq)
      else $error("interrupt output not raised");
endmodule

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the supply supervisor mode control
// Assumes: apb answer and lpm_ack sampled at the rising edge that completes them
// Notes: full-perf settings keep the fast deep test's settle and wake waits at 50 cycles
`timescale 1ns/10ps
module tb_top
   import supervisor_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, lpm_req, lpm_deep, wake_irq;
   logic ext_reset_req, power_up_clear, pready, pslverr, lpm_ack, wake_slow;
   logic cpu_hold, por_req, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   trips_t trip;
   sv_states_t sv_state;
   pmode_t pmode;
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   int k, h;
   logic [6:0] lt [4] = '{7'h00, 7'h01, 7'h1D, 7'h08};
   logic [6:0] ht [4] = '{7'h00, 7'h05, 7'h08, 7'h19};
   logic [7:0] st [4] = '{8'h00, 8'h21, 8'h4A, 8'h94};

   supply_supervisor_ctrl supply_supervisor_ctrl_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .lpm_req(lpm_req),
      .lpm_deep(lpm_deep), .lpm_ack(lpm_ack), .wake_irq(wake_irq),
      .ext_reset_req(ext_reset_req), .power_up_clear(power_up_clear), .trip(trip),
      .sv_state(sv_state), .pmode(pmode), .wake_slow(wake_slow), .cpu_hold(cpu_hold),
      .por_req(por_req), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic tally_and_finish;
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // hang guard: longest path is one slow settle plus two slow wakes
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // request stands until pready is seen at a rising edge; the hang guard ends a stall
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // k counts cycles from request to acknowledge
   task automatic lpm_enter(input logic deep, input logic wk, input pmode_t pm);
      k = 0;
      @(posedge pclk);
      lpm_req <= 1'b1;
      lpm_deep <= deep;
      wake_irq <= wk;
      do begin
         @(posedge pclk);
         k++;
      end while (lpm_ack !== 1'b1);
      chk(pmode, pm);
      lpm_req <= 1'b0;
      wake_irq <= 1'b0;
   endtask

   task automatic hold_len;
      h = 0;
      @(negedge pclk);
      while (pmode !== PM_ACTIVE) begin
         if (cpu_hold === 1'b1) begin
            h++;
         end
         @(negedge pclk);
      end
   endtask

   task automatic fire(input logic [3:0] t, input logic exp_por);
      @(posedge pclk);
      trip <= trips_t'(t);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk(por_req, exp_por);
      @(posedge pclk);
      trip <= '0;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk(por_req, 32'h0);
   endtask

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, lpm_req, lpm_deep, wake_irq} = 6'h00;
      {ext_reset_req, power_up_clear} = 2'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      trip = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(OFS_LCTL, 32'(LCTL_RST));
      rd_chk(OFS_HCTL, 32'(HCTL_RST));
      rd_chk(OFS_FLAGS, 32'h0);
      rd_chk(OFS_IMASK, 32'(IMASK_RST));
      rd_chk(OFS_STATE, 32'h455);
      rd_chk(8'h18, 32'h0);
      chk(err, 32'h1);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, OFS_LCTL, 32'(lt[i]));
         apb(1'b1, OFS_HCTL, 32'(ht[i]));
         rd_chk(OFS_LCTL, 32'(lt[i]));
         @(negedge pclk);
         chk(sv_state, st[i]);
      end
      $display("test active decode done");
      // low side and high supervisor full perf, high monitor normal: 50-cycle settle, fast wake, auto drop in deep
      apb(1'b1, OFS_LCTL, 32'h3F);
      apb(1'b1, OFS_HCTL, 32'h2D);
      rd_chk(OFS_FLAGS, 32'h3);
      lpm_enter(1'b1, 1'b0, PM_DEEP);
      chk(k >= 40, 32'h1);
      chk(sv_state, 8'h05);
      @(posedge pclk);
      wake_irq <= 1'b1;
      @(posedge pclk);
      wake_irq <= 1'b0;
      hold_len();
      chk(h >= int'(FAST_CYC) - 2 && h <= int'(FAST_CYC) + 2, 32'h1);
      chk(wake_slow, 32'h0);
      repeat (2) @(negedge pclk);
      chk(sv_state, 8'h6A);
      apb(1'b0, OFS_ISTAT, 32'h0);
      chk(rd[IRQ_WAKE], 32'h1);
      $display("test fast deep done");
      // manual, normal perf: slow path, interrupt in the acceptance cycle
      apb(1'b1, OFS_LCTL, 32'h0B);
      apb(1'b1, OFS_HCTL, 32'h0B);
      rd = 32'h3;
      for (int i = 0; i < 2000 && rd !== 32'h0; i++) begin
         apb(1'b0, OFS_FLAGS, 32'h0);
      end
      chk(rd, 32'h0);
      lpm_enter(1'b1, 1'b1, PM_WAKE);
      hold_len();
      chk(h >= int'(SLOW_CYC) - 2 && h <= int'(SLOW_CYC) + 2, 32'h1);
      chk(wake_slow, 32'h1);
      repeat (2) @(negedge pclk);
      chk(sv_state, 8'h55);
      // same settings, wake from inside deep sleep
      lpm_enter(1'b1, 1'b0, PM_DEEP);
      chk(sv_state, 8'h55);
      @(posedge pclk);
      wake_irq <= 1'b1;
      @(posedge pclk);
      wake_irq <= 1'b0;
      hold_len();
      chk(h >= int'(SLOW_CYC) - 2 && h <= int'(SLOW_CYC) + 2, 32'h1);
      $display("test slow deep done");
      for (int i = 0; i < 3; i++) begin
         lpm_enter(1'b0, 1'b0, PM_LIGHT);
         @(posedge pclk);
         ext_reset_req <= (i == 0);
         power_up_clear <= (i == 1);
         wake_irq <= (i == 2);
         @(posedge pclk);
         ext_reset_req <= 1'b0;
         power_up_clear <= 1'b0;
         wake_irq <= 1'b0;
         repeat (2) @(negedge pclk);
         chk(pmode, PM_ACTIVE);
      end
      $display("test light sleep done");
      // sticky status, mask and routing of events
      apb(1'b1, OFS_ISTAT, 32'h3F);
      apb(1'b1, OFS_IMASK, 32'h3F);
      rd_chk(OFS_ISTAT, 32'h0);
      fire(4'h9, 1'b0);
      chk(irq, 32'h1);
      rd_chk(OFS_ISTAT, 32'h09);
      apb(1'b1, OFS_IMASK, 32'h0);
      repeat (3) @(negedge pclk);
      chk(irq, 32'h0);
      apb(1'b1, OFS_ISTAT, 32'h09);
      rd_chk(OFS_ISTAT, 32'h0);
      apb(1'b1, OFS_LCTL, 32'h4B);
      fire(4'h1, 1'b1);
      apb(1'b1, OFS_HCTL, 32'h4B);
      fire(4'h8, 1'b1);
      $display("test events done");
      tally_and_finish();
   end
endmodule
